// ===== rxcs_sequencer.v
`timescale 1ns/100ps
`default_nettype none
`include "rxcs_defs.vh"

// What this block does
// - Host address strobe is synchronised before the sequencer uses it.
// - Decode address for cycle type; internal masters pipeline with select held.
// - State 1 asserts ROM select, expansion enable, lane output enables, inbound.
// - Internal master cycles drive the address on the edge asserting the strobes.
// - Settle wait length comes from the two-bit memory_config_one field, bits 3-4.
// - Wait input sampled ending state 4 and each wait state until inactive.
// - Final state steers bytes onto 64-bit phrase, latches, releases strobes.
// - For host cycles, acknowledge asserts together with latched read data.
// - Host may read wide ROMs and gets 16-bit reads assembled from 8-bit ROM.
// - Acknowledge and data hold until the third rising edge after the strobe is removed.
// - Zero-wait read takes five active states; slower settings add states.
// - Outputs from rising edge; byte write enables timed from falling edge.
// - Wait and host strobe are sampled only on the rising clock edge.
// - Acknowledge stays asserted until the host withdraws its request.
// - Expansion enable opens the transceivers on every ROM or peripheral transfer.
// - Low and high half output enables also set transceiver direction.
module rxcs_sequencer (
  // Clock, reset, enable
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // Static configuration
  input  wire [1:0]  memory_config_one_wait_i,
  input  wire [1:0]  rom_width_i,
  // Host processor bus
  input  wire        host_address_strobe_n_i,
  input  wire [23:0] host_addr_i,
  input  wire        host_read_i,
  input  wire        host_upper_n_i,
  input  wire        host_lower_n_i,
  input  wire [15:0] host_wdata_i,
  output wire        transfer_ack_n_o,
  output wire [15:0] host_rdata_o,
  output wire        host_rdata_oe_o,
  // Internal masters
  input  wire        int_req_i,
  input  wire [23:0] int_addr_i,
  input  wire        int_read_i,
  input  wire [31:0] int_wdata_i,
  output wire        int_accept_o,
  output wire        int_done_o,
  output wire [63:0] int_rdata_o,
  // Expansion side
  input  wire        wait_request_n_i,
  input  wire [31:0] xd_i,
  output wire [31:0] xd_o,
  output wire        xd_oe_o,
  output wire [23:0] addr_o,
  output wire        addr_oe_o,
  output wire        rom_select_n_o,
  output wire        expansion_enable_n_o,
  output wire [1:0]  output_enable_n_o,
  output wire [3:0]  write_enable_n_o,
  output wire        xcvr_outbound_o
);

  localparam [5:0] S_IDLE   = 6'h01;
  localparam [5:0] S_ACT    = 6'h02;
  localparam [5:0] S_SETTLE = 6'h04;
  localparam [5:0] S_WAIT   = 6'h08;
  localparam [5:0] S_FINAL  = 6'h10;
  localparam [5:0] S_HOLD   = 6'h20;

  reg  [5:0]  state_q;
  reg         owner_host_q;
  reg         read_q;
  reg         rom_q;
  reg         two_beats_q;
  reg         beat_q;
  reg         upper_q;
  reg         lower_q;
  reg  [2:0]  cnt_q;
  reg  [23:0] addr_q;
  reg         addr_oe_q;
  reg  [15:0] host_wdata_q;
  reg  [31:0] int_wdata_q;
  reg  [63:0] phrase_q;
  reg  [15:0] host_rdata_q;
  reg         host_rdata_oe_q;
  reg         ack_n_q;
  reg  [63:0] int_rdata_q;
  reg         int_done_q;
  reg         sel_n_q;
  reg         exp_n_q;
  reg  [31:0] xd_q;
  reg         xd_oe_q;
  reg  [3:0]  we_n_q;

  wire        strobe_n_s;
  wire        host_req;
  wire        last_beat;
  wire        int_is_rom;
  wire [63:0] lane_data;
  wire [7:0]  lane_mask;
  reg  [3:0]  bmask;
  reg  [31:0] wdata_lane;
  reg  [63:0] phrase_d;
  wire [63:0] host_word;
  integer     i;

  rxcs_sync #(
    .RESET_VAL (1'b1)
  ) u_strobe_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (host_address_strobe_n_i),
    .q_o   (strobe_n_s)
  );

  rxcs_lane u_lane (
    .data_i  (xd_i),
    .bmask_i (bmask),
    .width_i (rom_width_i),
    .off_i   (addr_q[2:0]),
    .data_o  (lane_data),
    .bmask_o (lane_mask)
  );

  // Host request is seen only through the rising-edge synchroniser
  assign host_req   = ~strobe_n_s;
  assign last_beat  = ~two_beats_q | beat_q;
  assign int_is_rom = int_addr_i[`RXCS_ROM_HI:`RXCS_ROM_LO] == `RXCS_ROM_MATCH;
  // Internal masters may queue the next access while the current one finishes
  assign int_accept_o = ((state_q == S_IDLE) & ~host_req) |
                        ((state_q == S_FINAL) & ~owner_host_q & last_beat & ~host_req &
                         (int_is_rom == rom_q));

  assign host_word = phrase_d >> {~addr_q[2:1], 4'h0};

  // Byte lanes used by the current beat on the 32-bit expansion bus
  always @* begin
    case (rom_width_i)
      `RXCS_W8:  bmask = `RXCS_LANE_B0;
      `RXCS_W16: bmask = owner_host_q ? {2'b00, upper_q, lower_q} : `RXCS_LANE_H0;
      default: begin
        if (!owner_host_q)
          bmask = `RXCS_LANE_ALL;
        else if (addr_q[1])
          bmask = {2'b00, upper_q, lower_q};
        else
          bmask = {upper_q, lower_q, 2'b00};
      end
    endcase
  end

  // Write data placed on the lanes of the current beat
  always @* begin
    if (!owner_host_q)
      wdata_lane = int_wdata_q;
    else begin
      case (rom_width_i)
        `RXCS_W8:  wdata_lane = {24'h00_0000,
                                 addr_q[0] ? host_wdata_q[7:0] : host_wdata_q[15:8]};
        `RXCS_W16: wdata_lane = {16'h0000, host_wdata_q};
        default:   wdata_lane = {host_wdata_q, host_wdata_q};
      endcase
    end
  end

  // Merge of this beat into the phrase; 8-bit beats build up a host word
  always @* begin
    phrase_d = phrase_q;
    for (i = 0; i < 8; i = i + 1) begin
      if (lane_mask[i])
        phrase_d[i*8 +: 8] = lane_data[i*8 +: 8];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q         <= S_IDLE;
      owner_host_q    <= 1'b0;
      read_q          <= 1'b1;
      rom_q           <= 1'b0;
      two_beats_q     <= 1'b0;
      beat_q          <= 1'b0;
      upper_q         <= 1'b0;
      lower_q         <= 1'b0;
      cnt_q           <= 3'h0;
      addr_q          <= 24'h00_0000;
      addr_oe_q       <= 1'b0;
      host_wdata_q    <= 16'h0000;
      int_wdata_q     <= 32'h0000_0000;
      phrase_q        <= 64'h0000_0000_0000_0000;
      host_rdata_q    <= 16'h0000;
      host_rdata_oe_q <= 1'b0;
      ack_n_q         <= 1'b1;
      int_rdata_q     <= 64'h0000_0000_0000_0000;
      int_done_q      <= 1'b0;
      sel_n_q         <= 1'b1;
      exp_n_q         <= 1'b1;
      xd_q            <= 32'h0000_0000;
      xd_oe_q         <= 1'b0;
    end else if (ce_i) begin
      int_done_q <= 1'b0;
      xd_q       <= wdata_lane;
      case (state_q)
        S_IDLE: begin
          if (host_req) begin
            // Host placed address and strobes before its request
            owner_host_q <= 1'b1;
            read_q       <= host_read_i;
            rom_q        <= host_addr_i[`RXCS_ROM_HI:`RXCS_ROM_LO] == `RXCS_ROM_MATCH;
            upper_q      <= ~host_upper_n_i;
            lower_q      <= ~host_lower_n_i;
            two_beats_q  <= (rom_width_i == `RXCS_W8) & ~host_upper_n_i & ~host_lower_n_i;
            beat_q       <= 1'b0;
            addr_q       <= {host_addr_i[23:1], host_upper_n_i};
            addr_oe_q    <= 1'b0;
            host_wdata_q <= host_wdata_i;
            sel_n_q      <= ~(host_addr_i[`RXCS_ROM_HI:`RXCS_ROM_LO] == `RXCS_ROM_MATCH);
            exp_n_q      <= 1'b0;
            xd_oe_q      <= ~host_read_i;
            state_q      <= S_ACT;
          end else if (int_req_i) begin
            owner_host_q <= 1'b0;
            read_q       <= int_read_i;
            rom_q        <= int_is_rom;
            two_beats_q  <= 1'b0;
            beat_q       <= 1'b0;
            addr_q       <= int_addr_i;
            addr_oe_q    <= 1'b1;
            int_wdata_q  <= int_wdata_i;
            sel_n_q      <= ~int_is_rom;
            exp_n_q      <= 1'b0;
            xd_oe_q      <= ~int_read_i;
            state_q      <= S_ACT;
          end
        end
        S_ACT: begin
          cnt_q   <= `RXCS_SETTLE_LAST + {1'b0, memory_config_one_wait_i};
          state_q <= S_SETTLE;
        end
        S_SETTLE: begin
          if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
          else if (wait_request_n_i)
            state_q <= S_FINAL;
          else
            state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (wait_request_n_i)
            state_q <= S_FINAL;
        end
        S_FINAL: begin
          phrase_q <= phrase_d;
          if (!last_beat) begin
            // Second byte of a host word from 8-bit ROM; strobes stay asserted
            beat_q    <= 1'b1;
            addr_q[0] <= 1'b1;
            state_q   <= S_ACT;
          end else if (owner_host_q) begin
            host_rdata_q    <= host_word[15:0];
            host_rdata_oe_q <= read_q;
            ack_n_q         <= 1'b0;
            sel_n_q         <= 1'b1;
            exp_n_q         <= 1'b1;
            xd_oe_q         <= 1'b0;
            addr_oe_q       <= 1'b0;
            state_q         <= S_HOLD;
          end else begin
            int_rdata_q <= phrase_d;
            int_done_q  <= 1'b1;
            if (int_req_i && int_accept_o) begin
              // Pipelined access to the same range keeps the select low
              read_q      <= int_read_i;
              addr_q      <= int_addr_i;
              int_wdata_q <= int_wdata_i;
              xd_oe_q     <= ~int_read_i;
              state_q     <= S_ACT;
            end else begin
              sel_n_q   <= 1'b1;
              exp_n_q   <= 1'b1;
              xd_oe_q   <= 1'b0;
              addr_oe_q <= 1'b0;
              state_q   <= S_IDLE;
            end
          end
        end
        S_HOLD: begin
          if (strobe_n_s) begin
            ack_n_q         <= 1'b1;
            host_rdata_oe_q <= 1'b0;
            state_q         <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Byte write enables change on the falling edge, inside the settle and wait states
  always @(negedge clk_i) begin
    if (rst_i)
      we_n_q <= `RXCS_LANE_ALL;
    else if (ce_i)
      we_n_q <= ~(bmask & {4{~read_q & (state_q == S_SETTLE | state_q == S_WAIT)}});
  end

  wire active = state_q == S_ACT | state_q == S_SETTLE | state_q == S_WAIT | state_q == S_FINAL;

  // Output enables also steer the transceivers inbound during reads
  assign output_enable_n_o    = ~({|bmask[3:2], |bmask[1:0]} & {2{read_q & active}});
  assign xcvr_outbound_o      = ~read_q & active;
  assign rom_select_n_o       = sel_n_q;
  assign expansion_enable_n_o = exp_n_q;
  assign write_enable_n_o     = we_n_q;
  assign addr_o               = addr_q;
  assign addr_oe_o            = addr_oe_q;
  assign xd_o                 = xd_q;
  assign xd_oe_o              = xd_oe_q;
  assign transfer_ack_n_o     = ack_n_q;
  assign host_rdata_o         = host_rdata_q;
  assign host_rdata_oe_o      = host_rdata_oe_q;
  assign int_done_o           = int_done_q;
  assign int_rdata_o          = int_rdata_q;

endmodule // rxcs_sequencer

`default_nettype wire

// ===== rxcs_defs.vh
`ifndef RXCS_DEFS_VH
`define RXCS_DEFS_VH

// ROM data path width strap codes
`define RXCS_W8             2'h0
`define RXCS_W16            2'h1
`define RXCS_W32            2'h2

// Settle states after state 1: base of three, minus one for the zero-based counter
`define RXCS_SETTLE_LAST    3'h2

// Address decode of the ROM range: top two address bits
`define RXCS_ROM_HI         23
`define RXCS_ROM_LO         22
`define RXCS_ROM_MATCH      2'h3

// Byte lane masks on the 32-bit expansion data bus
`define RXCS_LANE_B0        4'h1
`define RXCS_LANE_H0        4'h3
`define RXCS_LANE_ALL       4'hf
`define RXCS_LANE_NONE      4'h0

// Phrase geometry
`define RXCS_PHRASE_BYTES   4'h8

`endif

// ===== rxcs_sync.v
`timescale 1ns/100ps
`default_nettype none

module rxcs_sync #(
  parameter RESET_VAL = 1'b1
) (
  // Clock and control
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  // Asynchronous level in, synchronised level out
  input  wire d_i,
  output wire q_o
);

  reg meta_q;
  reg sync_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule // rxcs_sync

`default_nettype wire

// ===== rxcs_lane.v
`timescale 1ns/100ps
`default_nettype none
`include "rxcs_defs.vh"

// Places one beat of expansion bus data into a big-endian 64-bit phrase
module rxcs_lane (
  // Beat in
  input  wire [31:0] data_i,
  input  wire [3:0]  bmask_i,
  input  wire [1:0]  width_i,
  input  wire [2:0]  off_i,
  // Phrase out
  output wire [63:0] data_o,
  output wire [7:0]  bmask_o
);

  reg [3:0] pos;

  always @* begin
    case (width_i)
      `RXCS_W8:  pos = `RXCS_PHRASE_BYTES - {1'b0, off_i} - 4'h1;
      `RXCS_W16: pos = `RXCS_PHRASE_BYTES - {1'b0, off_i[2:1], 1'b0} - 4'h2;
      default:   pos = `RXCS_PHRASE_BYTES - {1'b0, off_i[2], 2'b00} - 4'h4;
    endcase
  end

  assign data_o  = {32'h0000_0000, data_i} << {pos[2:0], 3'b000};
  assign bmask_o = {4'h0, bmask_i} << pos[2:0];

endmodule // rxcs_lane

`default_nettype wire

// ===== rxcs_sequencer_properties.sv
`timescale 1ns/100ps
`default_nettype none

module rxcs_sequencer_properties (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Watched ports
  input wire logic        host_address_strobe_n_i,
  input wire logic        host_read_i,
  input wire logic        int_req_i,
  input wire logic [23:0] int_addr_i,
  input wire logic [1:0]  memory_config_one_wait_i,
  input wire logic        transfer_ack_n_o,
  input wire logic [15:0] host_rdata_o,
  input wire logic        host_rdata_oe_o,
  input wire logic [23:0] addr_o,
  input wire logic        addr_oe_o,
  input wire logic        rom_select_n_o,
  input wire logic        expansion_enable_n_o,
  input wire logic [1:0]  output_enable_n_o,
  input wire logic [3:0]  write_enable_n_o,
  input wire logic        xcvr_outbound_o,
  input wire logic        xd_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [3:0] run_q;

  // Length of the current select-low run, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || rom_select_n_o) begin
      run_q <= 4'h0;
    end else if (run_q != 4'hf) begin
      run_q <= run_q + 4'h1;
    end
  end

  a_sync_delay:
    assert property ($fell(host_address_strobe_n_i) && expansion_enable_n_o && !int_req_i
      |=> expansion_enable_n_o [*2]) else $error("request taken before synchroniser");
  a_five_states:
    assert property ($fell(rom_select_n_o) |-> !rom_select_n_o [*5])
      else $error("cycle shorter than five states");
  a_settle_len:
    assert property ($rose(rom_select_n_o) |-> run_q >= 4'd5 + memory_config_one_wait_i)
      else $error("settle count too short");
  a_sel_exp:
    assert property (!rom_select_n_o |-> !expansion_enable_n_o)
      else $error("select without expansion enable");
  a_oe_inbound:
    assert property (output_enable_n_o != 2'h3 |-> !xcvr_outbound_o && !xd_oe_o
      && !expansion_enable_n_o) else $error("output enable with wrong direction");
  a_we_outbound:
    assert property (write_enable_n_o != 4'hf |-> xcvr_outbound_o && xd_oe_o
      && output_enable_n_o == 2'h3) else $error("write enable with wrong direction");
  a_addr_edge:
    assert property ($fell(rom_select_n_o) && addr_oe_o |-> addr_o == $past(int_addr_i))
      else $error("address not changed with select");
  a_ack_edge:
    assert property ($fell(transfer_ack_n_o) |-> $rose(expansion_enable_n_o)
      && (host_rdata_oe_o || !host_read_i)) else $error("ack not at cycle end");
  a_ack_hold:
    assert property (!transfer_ack_n_o && !host_address_strobe_n_i
      |=> !transfer_ack_n_o && $stable(host_rdata_o)) else $error("ack or data not held");
  a_ack_release:
    assert property ($rose(host_address_strobe_n_i) && !transfer_ack_n_o
      |-> ##[1:3] transfer_ack_n_o) else $error("ack not released");

  c_host_read: cover property ($fell(transfer_ack_n_o) && host_read_i);
  c_write: cover property (write_enable_n_o != 4'hf);
  c_stretch: cover property ($rose(rom_select_n_o) && run_q > 4'd6);
  c_pipe: cover property (int_req_i && !rom_select_n_o);
endmodule // rxcs_sequencer_properties

bind rxcs_sequencer rxcs_sequencer_properties u_rxcs_sequencer_properties (.*);

`default_nettype wire

// ===== rxcs_rom_model.sv
`timescale 1ns/100ps
`default_nettype none

// ROM on the expansion side, with wait insertion
module rxcs_rom_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Setup from the bench
  input  wire logic [1:0]  width_i,
  input  wire logic [3:0]  lim_i,
  // Expansion side
  input  wire logic        sel_n_i,
  input  wire logic [1:0]  oe_n_i,
  input  wire logic [23:0] addr_i,
  output logic      [31:0] xd_o,
  output logic             wait_n_o
);
  logic [31:0] last_q;
  logic [3:0]  cnt_q;
  logic [31:0] word;

  function automatic logic [7:0] bt(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'ha5;
  endfunction

  // Undriven halves show a changing pattern, never the last value
  always_comb begin
    word = {bt({addr_i[23:2], 2'h0}), bt({addr_i[23:2], 2'h1}),
            bt({addr_i[23:2], 2'h2}), bt({addr_i[23:2], 2'h3})};
    if (width_i != 2'h2) begin
      word[15:0] = {bt({addr_i[23:1], 1'b0}), bt({addr_i[23:1], 1'b1})};
    end
    // Byte-wide part answers with the byte of the exact address on the low lane
    if (width_i == 2'h0) begin
      word[7:0] = bt(addr_i);
    end
    xd_o[31:16] = (!sel_n_i && !oe_n_i[1] && width_i == 2'h2) ? word[31:16] : ~last_q[31:16];
    xd_o[15:0] = (!sel_n_i && !oe_n_i[0]) ? word[15:0] : ~last_q[15:0];
    wait_n_o = sel_n_i || cnt_q >= lim_i;
  end

  always_ff @(posedge clk_i) begin
    last_q <= rst_i ? 32'h0 : xd_o;
    cnt_q <= (rst_i || sel_n_i) ? 4'h0 : cnt_q + 4'h1;
  end
endmodule // rxcs_rom_model

`default_nettype wire

// ===== rxcs_testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        clk_i, rst_i, ce_i, host_address_strobe_n_i, host_read_i, host_upper_n_i;
  logic        host_lower_n_i, int_req_i, int_read_i, wait_request_n_i, transfer_ack_n_o;
  logic        host_rdata_oe_o, int_accept_o, int_done_o, xd_oe_o, addr_oe_o, rom_select_n_o;
  logic        expansion_enable_n_o, xcvr_outbound_o;
  logic [1:0]  memory_config_one_wait_i, rom_width_i, output_enable_n_o;
  logic [3:0]  write_enable_n_o, lim;
  logic [15:0] host_wdata_i, host_rdata_o;
  logic [23:0] host_addr_i, int_addr_i, addr_o;
  logic [31:0] int_wdata_i, xd_i, xd_o;
  logic [63:0] int_rdata_o;
  int          err_total = 0;
  int          tests_run = 0;

  rxcs_sequencer u_rxcs_sequencer (.*);

  rxcs_rom_model u_rxcs_rom_model (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .width_i  (rom_width_i),
    .lim_i    (lim),
    .sel_n_i  (rom_select_n_o),
    .oe_n_i   (output_enable_n_o),
    .addr_i   (addr_oe_o ? addr_o : {host_addr_i[23:1], addr_o[0]}),
    .xd_o     (xd_i),
    .wait_n_o (wait_request_n_i)
  );

  function automatic logic [15:0] hw(input logic [23:0] a);
    return {a[7:1], 1'b0, a[7:1], 1'b1} ^ {2{a[15:8]}} ^ 16'ha5a5;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic host(input logic rd, input logic [23:0] a, input logic [1:0] st);
    int n;
    int f;
    int x;
    logic [3:0] we;
    logic [15:0] wd;
    logic [15:0] xo;
    @(posedge clk_i);
    f = memory_config_one_wait_i;
    x = (rom_width_i == 2'h0 && st == 2'h0) ? 5 + f : 0;
    wd = 16'($urandom);
    we = 4'hf;
    xo = 16'h0;
    host_read_i <= rd;
    host_addr_i <= a;
    {host_upper_n_i, host_lower_n_i} <= st;
    host_wdata_i <= wd;
    @(posedge clk_i);
    host_address_strobe_n_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
      we &= write_enable_n_o;
      if (write_enable_n_o != 4'hf && rom_width_i == 2'h0) xo[8 * !addr_o[0] +: 8] = xd_o[7:0];
      else if (write_enable_n_o != 4'hf) xo = xd_o[15:0];
    end while (transfer_ack_n_o !== 1'b0 && n < 200);
    chk(n, 8 + f + x + ((lim > 3 + f) ? lim - 3 - f : 0));
    if (rd) begin
      chk(host_rdata_o, hw(a));
    end else begin
      if (rom_width_i == 2'h0) chk(we, 4'he);
      else chk(we, (rom_width_i == 2'h2 && !a[1]) ? {st, 2'h3} : {2'h3, st});
      if (rom_width_i == 2'h0) chk(xo, {st[1] ? 8'h00 : wd[15:8], st[0] ? 8'h00 : wd[7:0]});
      else chk(xo, wd);
    end
    @(posedge clk_i);
    host_address_strobe_n_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (transfer_ack_n_o !== 1'b1 && n < 20);
    chk(n, 3);
  endtask

  // Two internal reads, request held so the second is pipelined
  task automatic intr(input logic [23:0] a0, input logic [23:0] a1);
    logic [23:0] q[$];
    int n;
    int s;
    logic tk;
    logic [15:0] g;
    logic [15:0] e;
    q = {a0, a1};
    @(posedge clk_i);
    int_addr_i <= a0;
    int_req_i <= 1'b1;
    s = 0;
    #1;
    tk = int_req_i === 1'b1 && int_accept_o === 1'b1;
    for (n = 0; n < 100 && q.size() > 0; n++) begin
      @(posedge clk_i);
      if (tk) begin
        s++;
        int_addr_i <= a1;
        if (s == 2) int_req_i <= 1'b0;
      end
      #1;
      if (int_done_o === 1'b1) begin
        e = hw(q[0]);
        g = int_rdata_o[63 - 8 * q[0][2:0] -: 16];
        if (rom_width_i == 2'h0) {g[7:0], e[7:0]} = 16'h0000;
        chk(g, e);
        if (q.size() == 2) chk(rom_select_n_o, 1'b0);
        void'(q.pop_front());
      end
      tk = int_req_i === 1'b1 && int_accept_o === 1'b1;
    end
    chk(q.size(), 0);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // About fifteen times the expected run
  initial begin
    #40000;
    err_total++;
    complete_run;
  end

  initial begin
    logic [23:0] a;
    rst_i = 1'b1;
    ce_i = 1'b1;
    host_address_strobe_n_i = 1'b1;
    {host_read_i, host_upper_n_i, host_lower_n_i, int_read_i} = 4'hf;
    {int_req_i, memory_config_one_wait_i, rom_width_i, lim} = 9'h010;
    {host_wdata_i, host_addr_i, int_addr_i, int_wdata_i} = 96'h0;
    void'($urandom(87852));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_i);
      memory_config_one_wait_i <= 2'(i % 4);
      rom_width_i <= 2'(i % 3);
      lim <= 4'($urandom % 9);
      a = {2'h3, 21'($urandom), 1'b0};
      host(1'b1, a, 2'h0);
      host(1'b0, a ^ 24'h2, 2'((i / 3) % 3));
      intr(a ^ 24'h4, a ^ 24'h6);
      $display("Test %0d done, mismatches %0d", i, err_total);
    end
    complete_run;
  end
endmodule // testbench

`default_nettype wire
